// ===== cbs_pkg.sv
// shared constants and types for the bit, shift and stack execution unit
package cbs_pkg;

  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 32;

  localparam logic [11:0] CMD_ADDR     = 12'h000;
  localparam logic [11:0] STATUS_ADDR  = 12'h004;
  localparam logic [11:0] FLAGS_ADDR   = 12'h008;
  localparam logic [11:0] SP_ADDR      = 12'h00C;
  localparam logic [11:0] WREG_BASE    = 12'h400;
  localparam logic [11:0] IO_BASE      = 12'h800;
  localparam logic [11:0] STACK_BASE   = 12'hC00;

  localparam int          CMD_OP_LSB   = 0;
  localparam int          CMD_BIT_LSB  = 4;
  localparam int          CMD_REG_LSB  = 8;
  localparam int          CMD_IO_LSB   = 16;
  localparam int          CMD_REG_W    = 5;
  localparam int          CMD_IO_W     = 6;

  localparam int          FLAG_C       = 0;
  localparam int          FLAG_Z       = 1;
  localparam int          FLAG_N       = 2;
  localparam int          FLAG_V       = 3;
  localparam int          FLAG_T       = 6;

  localparam int          STAT_BUSY    = 0;
  localparam int          STAT_SP_LSB  = 8;

  localparam logic [7:0]  FLAGS_RESET  = 8'h00;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [3:0] {
    CBS_PORT_OUT_OP,
    CBS_PUSH_OP,
    CBS_POP_OP,
    CBS_IO_BIT_SET_OP,
    CBS_IO_BIT_CLEAR_OP,
    CBS_SHIFT_LEFT_LOGICAL_OP,
    CBS_SHIFT_RIGHT_LOGICAL_OP,
    CBS_ROTATE_LEFT_CARRY_OP,
    CBS_ROTATE_RIGHT_CARRY_OP,
    CBS_SHIFT_RIGHT_SIGNED_OP,
    CBS_NIBBLE_SWAP_OP,
    CBS_STATUS_FLAG_SET_OP,
    CBS_STATUS_FLAG_CLEAR_OP,
    CBS_REG_BIT_TO_TRANSFER_OP,
    CBS_TRANSFER_TO_REG_BIT_OP,
    CBS_CARRY_SET_OP
  } cbs_op_t;

  typedef enum logic [1:0] {
    CBS_IDLE,
    CBS_EXEC1,
    CBS_EXEC2
  } cbs_state_t;

endpackage

// ===== cbs_exec_unit.sv
// bit, shift and stack execution unit with an axi4-lite register slave
// How it works
// - port output copies the working register to the io location, one cycle.
// - push stores the working register on the stack, flags kept, two cycles.
// - pop loads the working register from the stack, flags kept, two cycles.
// - io bit set forces one io bit high, others untouched, two cycles.
// - io bit clear forces one io bit low, others untouched, two cycles.
// - logical left shift inserts zero at bit 0, updates Z C N V.
// - logical right shift inserts zero at bit 7, updates Z C N V.
// - rotate left moves old carry to bit 0, bit 7 to carry.
// - rotate right moves old carry to bit 7, bit 0 to carry.
// - arithmetic right shift keeps bit 7, updates Z C N V, one cycle.
// - nibble swap exchanges register halves, flags unchanged, one cycle.
// - flag set forces the selected status bit to one only.
// - flag clear forces the selected status bit to zero only.
// - bit store copies a register bit into the transfer flag only.
// - bit load copies the transfer flag into one register bit only.
// - carry set forces carry high alone, one cycle.
`timescale 1ns/1ps

module cbs_exec_unit
  import cbs_pkg::*;
#(
  parameter int NUM_REGS    = 32,
  parameter int IO_WORDS    = 64,
  parameter int STACK_DEPTH = 16
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  localparam int RIDX_W = $clog2(NUM_REGS);
  localparam int IIDX_W = $clog2(IO_WORDS);
  localparam int SP_W   = $clog2(STACK_DEPTH);

  // the command fields and the 8-bit word index limit what can be reached
  if (NUM_REGS < 2 || NUM_REGS > 32 || (NUM_REGS & (NUM_REGS - 1)) != 0 ||
      IO_WORDS < 2 || IO_WORDS > 64 || (IO_WORDS & (IO_WORDS - 1)) != 0 ||
      STACK_DEPTH < 2 || STACK_DEPTH > 256 ||
      (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_params
    $error("cbs_exec_unit: unsupported array sizes");
  end

  typedef struct packed {
    cbs_state_t                  state;
    logic [DATA_W-1:0]           cmd;
    logic [7:0]                  flags;
    logic [SP_W-1:0]             sp;
    logic [NUM_REGS-1:0][7:0]    wreg;
    logic [IO_WORDS-1:0][7:0]    io;
    logic [STACK_DEPTH-1:0][7:0] stack;
    logic                        aw_have;
    logic [ADDR_W-1:0]           awaddr;
    logic                        w_have;
    logic [DATA_W-1:0]           wdata;
    logic [DATA_W/8-1:0]         wstrb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [DATA_W-1:0]           rdata;
    logic [1:0]                  rresp;
  } cbs_st_t;

  // stack pointer starts at the top and grows downward
  localparam cbs_st_t ST_RESET = '{state: CBS_IDLE, flags: FLAGS_RESET,
                                   sp: '1, default: '0};

  cbs_st_t q;
  cbs_st_t d;

  // region in addr[11:10], word index in addr[9:2]
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic [7:0] wi;
    wi = a[9:2];
    addr_ok = 1'b0;
    if (a[1:0] == 2'b00) begin
      if (a[11:10] == CMD_ADDR[11:10]) begin
        addr_ok = (a == CMD_ADDR) || (a == STATUS_ADDR) ||
                  (a == FLAGS_ADDR) || (a == SP_ADDR);
      end else if (a[11:10] == WREG_BASE[11:10]) begin
        addr_ok = 32'(wi) < NUM_REGS;
      end else if (a[11:10] == IO_BASE[11:10]) begin
        addr_ok = 32'(wi) < IO_WORDS;
      end else begin
        addr_ok = 32'(wi) < STACK_DEPTH;
      end
    end
  endfunction

  // returns {carry_out, result} for the five shift and rotate kinds
  function automatic logic [8:0] shift_calc(input cbs_op_t    op,
                                            input logic [7:0] v,
                                            input logic       c);
    shift_calc = {c, v};
    unique case (op)
      CBS_SHIFT_LEFT_LOGICAL_OP:  shift_calc = {v[7], v[6:0], 1'b0};
      CBS_SHIFT_RIGHT_LOGICAL_OP: shift_calc = {v[0], 1'b0, v[7:1]};
      CBS_ROTATE_LEFT_CARRY_OP:   shift_calc = {v[7], v[6:0], c};
      CBS_ROTATE_RIGHT_CARRY_OP:  shift_calc = {v[0], c, v[7:1]};
      CBS_SHIFT_RIGHT_SIGNED_OP:  shift_calc = {v[0], v[7], v[7:1]};
      default:                    shift_calc = {c, v};
    endcase
  endfunction

  cbs_op_t           op;
  logic [RIDX_W-1:0] ridx;
  logic [IIDX_W-1:0] ioidx;
  logic [2:0]        bsel;
  logic [7:0]        rd_val;
  logic [7:0]        io_val;
  logic [SP_W-1:0]   sp_inc;
  logic              is_shift;
  logic [8:0]        sh;
  logic              wr_go;
  logic              rd_go;
  logic [7:0]        wi_w;
  logic [7:0]        wi_r;

  assign op       = cbs_op_t'(q.cmd[CMD_OP_LSB +: 4]);
  assign ridx     = q.cmd[CMD_REG_LSB +: RIDX_W];
  assign ioidx    = q.cmd[CMD_IO_LSB +: IIDX_W];
  assign bsel     = q.cmd[CMD_BIT_LSB +: 3];
  assign rd_val   = q.wreg[ridx];
  assign io_val   = q.io[ioidx];
  assign sp_inc   = q.sp + 1'b1;
  assign is_shift = op inside {CBS_SHIFT_LEFT_LOGICAL_OP,
                               CBS_SHIFT_RIGHT_LOGICAL_OP,
                               CBS_ROTATE_LEFT_CARRY_OP,
                               CBS_ROTATE_RIGHT_CARRY_OP,
                               CBS_SHIFT_RIGHT_SIGNED_OP};
  assign sh       = shift_calc(op, rd_val, q.flags[FLAG_C]);
  // writes wait while a command runs so software never races the datapath
  assign wr_go    = q.aw_have && q.w_have && !q.bvalid &&
                    (q.state == CBS_IDLE);
  assign rd_go    = s_axi_arvalid && !q.rvalid;
  assign wi_w     = q.awaddr[9:2];
  assign wi_r     = s_axi_araddr[9:2];

  assign s_axi_awready = !q.aw_have && !q.bvalid;
  assign s_axi_wready  = !q.w_have && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

  always_comb begin
    d = q;
    // address and data latch independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_have = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_have = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_go) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = addr_ok(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (addr_ok(q.awaddr)) begin
        if (q.awaddr == CMD_ADDR) begin
          // a command write always starts execution
          for (int i = 0; i < DATA_W / 8; i++) begin
            if (q.wstrb[i]) begin
              d.cmd[8*i +: 8] = q.wdata[8*i +: 8];
            end
          end
          d.state = CBS_EXEC1;
        end else if (q.wstrb[0]) begin
          if (q.awaddr == FLAGS_ADDR) begin
            d.flags = q.wdata[7:0];
          end else if (q.awaddr == SP_ADDR) begin
            d.sp = q.wdata[SP_W-1:0];
          end else if (q.awaddr[11:10] == WREG_BASE[11:10]) begin
            d.wreg[wi_w[RIDX_W-1:0]] = q.wdata[7:0];
          end else if (q.awaddr[11:10] == IO_BASE[11:10]) begin
            d.io[wi_w[IIDX_W-1:0]] = q.wdata[7:0];
          end else if (q.awaddr[11:10] == STACK_BASE[11:10]) begin
            d.stack[wi_w[SP_W-1:0]] = q.wdata[7:0];
          end
        end
      end
    end

    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rdata  = '0;
      d.rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (!addr_ok(s_axi_araddr)) begin
        d.rdata = '0;
      end else if (s_axi_araddr == CMD_ADDR) begin
        d.rdata = q.cmd;
      end else if (s_axi_araddr == STATUS_ADDR) begin
        d.rdata[STAT_BUSY]             = (q.state != CBS_IDLE);
        d.rdata[STAT_SP_LSB +: SP_W]   = q.sp;
      end else if (s_axi_araddr == FLAGS_ADDR) begin
        d.rdata[7:0] = q.flags;
      end else if (s_axi_araddr == SP_ADDR) begin
        d.rdata[SP_W-1:0] = q.sp;
      end else if (s_axi_araddr[11:10] == WREG_BASE[11:10]) begin
        d.rdata[7:0] = q.wreg[wi_r[RIDX_W-1:0]];
      end else if (s_axi_araddr[11:10] == IO_BASE[11:10]) begin
        d.rdata[7:0] = q.io[wi_r[IIDX_W-1:0]];
      end else begin
        d.rdata[7:0] = q.stack[wi_r[SP_W-1:0]];
      end
    end

    unique case (q.state)
      CBS_IDLE: begin
      end
      CBS_EXEC1: begin
        d.state = CBS_IDLE;
        unique case (op)
          CBS_PORT_OUT_OP: d.io[ioidx] = rd_val;
          CBS_PUSH_OP, CBS_POP_OP, CBS_IO_BIT_SET_OP,
          CBS_IO_BIT_CLEAR_OP: d.state = CBS_EXEC2;
          CBS_SHIFT_LEFT_LOGICAL_OP, CBS_SHIFT_RIGHT_LOGICAL_OP,
          CBS_ROTATE_LEFT_CARRY_OP, CBS_ROTATE_RIGHT_CARRY_OP,
          CBS_SHIFT_RIGHT_SIGNED_OP: begin
            d.wreg[ridx]   = sh[7:0];
            d.flags[FLAG_C] = sh[8];
            d.flags[FLAG_Z] = (sh[7:0] == 8'h00);
            d.flags[FLAG_N] = sh[7];
            // overflow is negative xor carry after the shift
            d.flags[FLAG_V] = sh[7] ^ sh[8];
          end
          CBS_NIBBLE_SWAP_OP: d.wreg[ridx] = {rd_val[3:0], rd_val[7:4]};
          CBS_STATUS_FLAG_SET_OP:     d.flags[bsel] = 1'b1;
          CBS_STATUS_FLAG_CLEAR_OP:   d.flags[bsel] = 1'b0;
          CBS_REG_BIT_TO_TRANSFER_OP: d.flags[FLAG_T] = rd_val[bsel];
          CBS_TRANSFER_TO_REG_BIT_OP: d.wreg[ridx][bsel] = q.flags[FLAG_T];
          CBS_CARRY_SET_OP:           d.flags[FLAG_C] = 1'b1;
        endcase
      end
      CBS_EXEC2: begin
        d.state = CBS_IDLE;
        if (op == CBS_PUSH_OP) begin
          // post-decrement; a full stack wraps and overwrites the oldest
          d.stack[q.sp] = rd_val;
          d.sp          = q.sp - 1'b1;
        end else if (op == CBS_POP_OP) begin
          d.sp          = sp_inc;
          d.wreg[ridx]  = q.stack[sp_inc];
        end else if (op == CBS_IO_BIT_SET_OP) begin
          d.io[ioidx][bsel] = 1'b1;
        end else if (op == CBS_IO_BIT_CLEAR_OP) begin
          d.io[ioidx][bsel] = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic ex1;
  assign ex1 = (q.state == CBS_EXEC1);

  sequence s_one;
    q.state == CBS_IDLE;
  endsequence
  sequence s_two;
    q.state == CBS_EXEC2 ##1 q.state == CBS_IDLE;
  endsequence

  property p_out;
    ex1 && op == CBS_PORT_OUT_OP |=> s_one and
      (io_val == $past(rd_val) && q.flags == $past(q.flags));
  endproperty
  a_out: assert property (p_out) else $error("port out wrong");

  property p_push;
    ex1 && op == CBS_PUSH_OP |=> s_two ##0
      (q.stack[sp_inc] == $past(rd_val, 2) && q.flags == $past(q.flags, 2)
       && sp_inc == $past(q.sp, 2));
  endproperty
  a_push: assert property (p_push) else $error("push wrong");

  property p_pop;
    ex1 && op == CBS_POP_OP |=> s_two ##0
      (rd_val == q.stack[q.sp] && q.sp == SP_W'($past(q.sp, 2) + 1'b1)
       && q.flags == $past(q.flags, 2));
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");

  property p_io_set;
    ex1 && op == CBS_IO_BIT_SET_OP |=> s_two ##0
      (io_val == ($past(io_val, 2) | (8'h01 << bsel)));
  endproperty
  a_io_set: assert property (p_io_set) else $error("io set wrong");

  property p_io_clr;
    ex1 && op == CBS_IO_BIT_CLEAR_OP |=> s_two ##0
      (io_val == ($past(io_val, 2) & ~(8'h01 << bsel))
       && q.flags == $past(q.flags, 2));
  endproperty
  a_io_clr: assert property (p_io_clr) else $error("io clear wrong");

  property p_lsl;
    ex1 && op == CBS_SHIFT_LEFT_LOGICAL_OP |=> s_one and
      (rd_val == {$past(rd_val[6:0]), 1'b0} &&
       q.flags[FLAG_C] == $past(rd_val[7]));
  endproperty
  a_lsl: assert property (p_lsl) else $error("left shift wrong");

  property p_lsr;
    ex1 && op == CBS_SHIFT_RIGHT_LOGICAL_OP |=>
      rd_val == {1'b0, $past(rd_val[7:1])} &&
      q.flags[FLAG_C] == $past(rd_val[0]);
  endproperty
  a_lsr: assert property (p_lsr) else $error("right shift wrong");

  property p_rol;
    ex1 && op == CBS_ROTATE_LEFT_CARRY_OP |=>
      rd_val == {$past(rd_val[6:0]), $past(q.flags[FLAG_C])} &&
      q.flags[FLAG_C] == $past(rd_val[7]);
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong");

  property p_ror;
    ex1 && op == CBS_ROTATE_RIGHT_CARRY_OP |=>
      rd_val == {$past(q.flags[FLAG_C]), $past(rd_val[7:1])} &&
      q.flags[FLAG_C] == $past(rd_val[0]);
  endproperty
  a_ror: assert property (p_ror) else $error("rotate right wrong");

  property p_asr;
    ex1 && op == CBS_SHIFT_RIGHT_SIGNED_OP |=>
      rd_val == {$past(rd_val[7]), $past(rd_val[7:1])} &&
      q.flags[FLAG_V] == (q.flags[FLAG_N] ^ q.flags[FLAG_C]);
  endproperty
  a_asr: assert property (p_asr) else $error("signed shift wrong");

  property p_swap;
    ex1 && op == CBS_NIBBLE_SWAP_OP |=> s_one and
      (rd_val == {$past(rd_val[3:0]), $past(rd_val[7:4])} &&
       q.flags == $past(q.flags));
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_fset;
    ex1 && op == CBS_STATUS_FLAG_SET_OP |=>
      q.flags == ($past(q.flags) | (8'h01 << bsel));
  endproperty
  a_fset: assert property (p_fset) else $error("flag set wrong");

  property p_fclr;
    ex1 && op == CBS_STATUS_FLAG_CLEAR_OP |=>
      q.flags == ($past(q.flags) & ~(8'h01 << bsel));
  endproperty
  a_fclr: assert property (p_fclr) else $error("flag clear wrong");

  property p_bst;
    ex1 && op == CBS_REG_BIT_TO_TRANSFER_OP |=>
      q.flags[FLAG_T] == $past(rd_val[bsel]) && rd_val == $past(rd_val);
  endproperty
  a_bst: assert property (p_bst) else $error("bit store wrong");

  property p_bld;
    ex1 && op == CBS_TRANSFER_TO_REG_BIT_OP |=>
      rd_val[bsel] == $past(q.flags[FLAG_T]) && q.flags == $past(q.flags);
  endproperty
  a_bld: assert property (p_bld) else $error("bit load wrong");

  property p_sec;
    ex1 && op == CBS_CARRY_SET_OP |=> s_one and
      (q.flags == ($past(q.flags) | 8'h01));
  endproperty
  a_sec: assert property (p_sec) else $error("carry set wrong");

  property p_zn;
    ex1 && is_shift |=> q.flags[FLAG_Z] == (rd_val == 8'h00) &&
      q.flags[FLAG_N] == rd_val[7];
  endproperty
  a_zn: assert property (p_zn) else $error("zero or negative wrong");

endmodule

// ===== cpu_bit_shift_stack_ops_test.sv
// self-checking bench for the bit, shift and stack execution unit
`timescale 1ns/1ps

module cpu_bit_shift_stack_ops_test;
  import cbs_pkg::*;

  localparam int DEPTH = 16;

  logic                aclk;
  logic                aresetn;
  logic [ADDR_W-1:0]   s_axi_awaddr;
  logic                s_axi_awvalid;
  logic                s_axi_awready;
  logic [DATA_W-1:0]   s_axi_wdata;
  logic [DATA_W/8-1:0] s_axi_wstrb;
  logic                s_axi_wvalid;
  logic                s_axi_wready;
  logic [1:0]          s_axi_bresp;
  logic                s_axi_bvalid;
  logic                s_axi_bready;
  logic [ADDR_W-1:0]   s_axi_araddr;
  logic                s_axi_arvalid;
  logic                s_axi_arready;
  logic [DATA_W-1:0]   s_axi_rdata;
  logic [1:0]          s_axi_rresp;
  logic                s_axi_rvalid;
  logic                s_axi_rready;
  logic [7:0]          vals [4];
  logic [15:0]         e;
  logic [7:0]          f0;
  logic [31:0]         d;
  int                  errors;
  int                  checked;

  cbs_exec_unit #(.STACK_DEPTH(DEPTH)) u_cbs_exec_unit (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic guard(inout int n);
    n++;
    if (n > 200) begin
      errors++;
      summarize();
    end
  endtask

  // each channel released only at its own handshake edge
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    logic aw_p;
    logic w_p;
    int   n;
    aw_p = 1'b1;
    w_p = 1'b1;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      guard(n);
      if (aw_p && s_axi_awready === 1'b1) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready === 1'b1) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    input logic [1:0] er);
    logic ar_p;
    int   n;
    ar_p = 1'b1;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      guard(n);
      if (ar_p && s_axi_arready === 1'b1) begin
        ar_p = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1) break;
    end
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rresp), 32'(er));
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v, RESP_OKAY);
    chk(v, exp);
  endtask

  function automatic logic [11:0] wreg(input int i);
    return WREG_BASE + 12'(4 * i);
  endfunction

  function automatic logic [11:0] iow(input int i);
    return IO_BASE + 12'(4 * i);
  endfunction

  // status is polled since the note allows reads while busy
  task automatic run(input cbs_op_t op, input int b, input int r,
                     input int p);
    logic [31:0] s;
    int          n;
    n = 0;
    wr(CMD_ADDR, 32'(op) | 32'(b) << CMD_BIT_LSB | 32'(r) << CMD_REG_LSB
       | 32'(p) << CMD_IO_LSB, RESP_OKAY);
    s = 32'h1;
    while (s[STAT_BUSY] !== 1'b0) begin
      guard(n);
      rd(STATUS_ADDR, s, RESP_OKAY);
    end
  endtask

  function automatic logic [15:0] model(input int op, input logic [7:0] v,
                                        input logic [7:0] f);
    logic [7:0] r;
    logic       c;
    case (op)
      5: {c, r} = {v, 1'b0};
      6: {r, c} = {1'b0, v};
      7: {c, r} = {v, f[FLAG_C]};
      8: {r, c} = {f[FLAG_C], v};
      9: {r, c} = {v[7], v};
      default: return {f, v[3:0], v[7:4]};
    endcase
    f[FLAG_C] = c;
    f[FLAG_Z] = (r == 8'h00);
    f[FLAG_N] = r[7];
    f[FLAG_V] = r[7] ^ c;
    return {f, r};
  endfunction

  initial begin
    errors = 0;
    checked = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    vals = '{8'h00, 8'h80, 8'h01, 8'hB5};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(FLAGS_ADDR, 32'(FLAGS_RESET));
    rchk(SP_ADDR, 32'(DEPTH - 1));
    rd(12'h010, d, RESP_SLVERR);
    chk(d, 32'h0);
    wr(12'h002, 32'hFF, RESP_SLVERR);
    wr(STATUS_ADDR, 32'h1, RESP_OKAY);
    rchk(STATUS_ADDR, 32'(DEPTH - 1) << STAT_SP_LSB);
    $display("test registers done");
    for (int op = 5; op <= 10; op++) begin
      foreach (vals[i]) begin
        for (int c = 0; c < 2; c++) begin
          f0 = 8'h70 | 8'(c);
          e = model(op, vals[i], f0);
          wr(wreg(7), 32'(vals[i]), RESP_OKAY);
          wr(FLAGS_ADDR, 32'(f0), RESP_OKAY);
          run(cbs_op_t'(op), 0, 7, 0);
          rchk(wreg(7), 32'(e[7:0]));
          rchk(FLAGS_ADDR, 32'(e[15:8]));
        end
      end
    end
    $display("test shifts done");
    for (int b = 0; b < 8; b++) begin
      wr(FLAGS_ADDR, 32'h0, RESP_OKAY);
      run(CBS_STATUS_FLAG_SET_OP, b, 0, 0);
      rchk(FLAGS_ADDR, 32'h1 << b);
      wr(FLAGS_ADDR, 32'hFF, RESP_OKAY);
      run(CBS_STATUS_FLAG_CLEAR_OP, b, 0, 0);
      rchk(FLAGS_ADDR, 32'hFF ^ (32'h1 << b));
    end
    wr(FLAGS_ADDR, 32'h5A, RESP_OKAY);
    run(CBS_CARRY_SET_OP, 0, 0, 0);
    rchk(FLAGS_ADDR, 32'h5B);
    $display("test flags done");
    wr(wreg(2), 32'h20, RESP_OKAY);
    wr(FLAGS_ADDR, 32'h0F, RESP_OKAY);
    run(CBS_REG_BIT_TO_TRANSFER_OP, 5, 2, 0);
    rchk(FLAGS_ADDR, 32'h4F);
    wr(wreg(9), 32'h00, RESP_OKAY);
    run(CBS_TRANSFER_TO_REG_BIT_OP, 3, 9, 0);
    rchk(wreg(9), 32'h08);
    run(CBS_REG_BIT_TO_TRANSFER_OP, 0, 2, 0);
    rchk(FLAGS_ADDR, 32'h0F);
    wr(wreg(9), 32'hFF, RESP_OKAY);
    run(CBS_TRANSFER_TO_REG_BIT_OP, 7, 9, 0);
    rchk(wreg(9), 32'h7F);
    rchk(FLAGS_ADDR, 32'h0F);
    $display("test transfer flag done");
    wr(wreg(1), 32'h3C, RESP_OKAY);
    wr(FLAGS_ADDR, 32'h2B, RESP_OKAY);
    run(CBS_PORT_OUT_OP, 0, 1, 63);
    rchk(iow(63), 32'h3C);
    wr(iow(5), 32'h5A, RESP_OKAY);
    run(CBS_IO_BIT_SET_OP, 0, 0, 5);
    rchk(iow(5), 32'h5B);
    run(CBS_IO_BIT_CLEAR_OP, 6, 0, 5);
    rchk(iow(5), 32'h1B);
    rchk(FLAGS_ADDR, 32'h2B);
    $display("test io done");
    wr(wreg(3), 32'hA5, RESP_OKAY);
    run(CBS_PUSH_OP, 0, 3, 0);
    rchk(STACK_BASE + 12'(4 * (DEPTH - 1)), 32'hA5);
    rchk(SP_ADDR, 32'(DEPTH - 2));
    run(CBS_POP_OP, 0, 4, 0);
    rchk(wreg(4), 32'hA5);
    rchk(SP_ADDR, 32'(DEPTH - 1));
    rchk(FLAGS_ADDR, 32'h2B);
    $display("test stack done");
    summarize();
  end

endmodule
